// ### rtl/lcdc_pkg.sv
package lcdc_pkg;

  localparam int BUS_W    = 8;       // host bus width
  localparam int COLS     = 64;      // segment outputs
  localparam int LINE_W   = 6;       // line and column counter width
  localparam int PAGE_W   = 3;       // page register width
  localparam int RAM_D    = 512;     // display RAM bytes
  localparam int CLK_MHZ  = 40;      // system clock rate

  // reset condition stays visible in status this long after release
  localparam int RST_HOLD_NS  = 200;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

  // status byte bit positions
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_OFF_BIT   = 5;
  localparam int ST_RST_BIT   = 4;

  // instruction patterns: code & mask == value
  localparam logic [7:0] ONOFF_MASK = 8'hFE;
  localparam logic [7:0] ONOFF_VAL  = 8'h3E;
  localparam logic [7:0] START_MASK = 8'hC0;
  localparam logic [7:0] START_VAL  = 8'hC0;
  localparam logic [7:0] PAGE_MASK  = 8'hF8;
  localparam logic [7:0] PAGE_VAL   = 8'hB8;
  localparam logic [7:0] COLA_MASK  = 8'hC0;
  localparam logic [7:0] COLA_VAL   = 8'h40;

  localparam logic [5:0] LINE_RST  = 6'h00;  // start line after reset
  localparam logic [5:0] COL_STEP  = 6'h01;  // column auto increment
  localparam logic       DISP_RST  = 1'b0;   // display off after reset

  // queued operation kinds, binary codes written out
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_WRITE = 3'b001,
    OP_READ  = 3'b010,
    OP_ONOFF = 3'b011,
    OP_START = 3'b100,
    OP_PAGE  = 3'b101,
    OP_COL   = 3'b110
  } lcdc_op_t;

  // segment drive levels
  typedef enum logic [1:0] {
    LVL_V1 = 2'b00,
    LVL_V2 = 2'b01,
    LVL_V3 = 2'b10,
    LVL_V4 = 2'b11
  } lcdc_lvl_t;

  // host pins as sampled together
  typedef struct packed {
    logic             strb;
    logic             cs_a_n;
    logic             cs_b_n;
    logic             cs_c;
    logic             rnw;
    logic             dnc;
    logic [BUS_W-1:0] data;
  } lcdc_pins_t;

  // operation handed from host side to phase-clock side
  typedef struct packed {
    lcdc_op_t         op;
    logic [BUS_W-1:0] data;
  } lcdc_cmd_t;

  // map an instruction or data access onto an operation kind
  function automatic lcdc_op_t lcdc_decode(input logic dnc,
                                           input logic rnw,
                                           input logic [7:0] code);
    lcdc_op_t k;
    k = OP_NONE;
    if (dnc) begin
      k = rnw ? OP_READ : OP_WRITE;
    end else if (!rnw) begin
      if ((code & ONOFF_MASK) == ONOFF_VAL) k = OP_ONOFF;
      else if ((code & START_MASK) == START_VAL) k = OP_START;
      else if ((code & PAGE_MASK) == PAGE_VAL) k = OP_PAGE;
      else if ((code & COLA_MASK) == COLA_VAL) k = OP_COL;
    end
    return k;
  endfunction : lcdc_decode

endpackage : lcdc_pkg

// ### rtl/lcdc_core.sv
`timescale 1ns/1ps
module lcdc_core (
  input  wire logic                        clock_i,         // system clock
  input  wire logic                        phase_clk_i,     // row drv phase
  input  wire logic                        rst_i,           // async, high
  input  wire logic                        host_strb_i,     // host strobe
  input  wire logic                        chip_sel_n_a_i,  // select, low
  input  wire logic                        chip_sel_n_b_i,  // select, low
  input  wire logic                        chip_sel_c_i,    // select, high
  input  wire logic                        read_not_write_i,
  input  wire logic                        data_or_cmd_i,
  input  wire logic [lcdc_pkg::BUS_W-1:0]  host_bus_i,
  output logic      [lcdc_pkg::BUS_W-1:0]  host_bus_o,
  output logic                             host_bus_oe_n_o, // low = drive
  input  wire logic                        column_order_i,
  input  wire logic                        ac_phase_i,
  input  wire logic                        frame_sync_i,
  input  wire logic                        line_latch_i,
  output lcdc_pkg::lcdc_lvl_t [lcdc_pkg::COLS-1:0] segment_outputs_o
);
  import lcdc_pkg::*;

  // host-side state, all on clock_i
  typedef struct packed {
    lcdc_pins_t       p1;        // first sync stage, read by p2 only
    lcdc_pins_t       p2;        // second sync stage
    logic             strb_prev; // strobe edge detector
    logic             ack1;      // ack toggle sync
    logic             ack2;
    logic             on1;       // display state sync
    logic             on2;
    logic             req_tgl;   // request toggle to phase side
    lcdc_cmd_t        cmd;       // input staging, stable while open
    logic [7:0]       rst_cnt;   // reset condition countdown
    logic             drive;     // bus output enable, active high
    logic [BUS_W-1:0] bus_out;   // bus data from flop
  } lcdc_host_t;

  // phase-clock-side state: RAM, address, display path
  typedef struct packed {
    logic                          req1;     // request toggle sync
    logic                          req2;
    logic                          ack_tgl;  // echoes served request
    logic                          fr1;      // frame_sync sync
    logic                          fr2;
    logic                          fr_prev;
    logic                          ll1;      // line_latch sync
    logic                          ll2;
    logic                          ll_prev;
    logic                          ac1;      // ac_phase sync
    logic                          ac2;
    logic                          co1;      // column_order sync
    logic                          co2;
    logic                          disp_on;  // display on/off flip-flop
    logic [LINE_W-1:0]             start;    // start line register
    logic [LINE_W-1:0]             line;     // display line counter
    logic [PAGE_W-1:0]             page;     // page register
    logic [LINE_W-1:0]             col;      // column counter
    logic [BUS_W-1:0]              out_reg;  // output staging register
    logic [COLS-1:0]               latch;    // latched line of pixels
    lcdc_lvl_t [COLS-1:0]          seg;      // segment levels, flopped
    logic [RAM_D-1:0][BUS_W-1:0]   ram;      // display RAM
  } lcdc_op_st_t;

  lcdc_host_t  h_r;
  lcdc_host_t  h_nxt;
  lcdc_op_st_t o_r;
  lcdc_op_st_t o_nxt;

  // one segment level from ac phase and pixel
  function automatic lcdc_lvl_t seg_level(input logic ac, input logic d);
    lcdc_lvl_t l;
    if (ac) l = d ? LVL_V1 : LVL_V3;
    else    l = d ? LVL_V2 : LVL_V4;
    return l;
  endfunction : seg_level

  // RAM byte address from page and column
  function automatic logic [PAGE_W+LINE_W-1:0] ram_addr(
      input logic [PAGE_W-1:0] pg, input logic [LINE_W-1:0] cl);
    return {pg, cl};
  endfunction : ram_addr

  // ---------------------------------------------------------------
  // host side: sync pins, decode, hand requests over, drive the bus
  // ---------------------------------------------------------------
  logic       sel;       // chip selected
  logic       busy;      // request outstanding
  logic       in_rst;    // reset condition still visible
  logic       fall;      // selected strobe falling edge
  logic [7:0] status;    // status byte
  lcdc_op_t   kind;      // decoded operation

  always_comb begin
    h_nxt = h_r;
    // every pin through two flops before use
    h_nxt.p1 = '{strb: host_strb_i, cs_a_n: chip_sel_n_a_i,
                 cs_b_n: chip_sel_n_b_i, cs_c: chip_sel_c_i,
                 rnw: read_not_write_i, dnc: data_or_cmd_i,
                 data: host_bus_i};
    h_nxt.p2 = h_r.p1;
    h_nxt.strb_prev = h_r.p2.strb;
    h_nxt.ack1 = o_r.ack_tgl;
    h_nxt.ack2 = h_r.ack1;
    h_nxt.on1  = o_r.disp_on;
    h_nxt.on2  = h_r.on1;
    // reset condition fades a fixed time after release
    if (h_r.rst_cnt != 8'h00) begin
      h_nxt.rst_cnt = h_r.rst_cnt - 8'h01;
    end

    sel    = !h_r.p2.cs_a_n && !h_r.p2.cs_b_n && h_r.p2.cs_c;
    busy   = h_r.req_tgl != h_r.ack2;
    in_rst = h_r.rst_cnt != 8'h00;
    fall   = sel && h_r.strb_prev && !h_r.p2.strb;
    status = 8'h00;
    status[ST_BUSY_BIT] = busy;
    status[ST_OFF_BIT]  = !h_r.on2;
    status[ST_RST_BIT]  = in_rst;
    kind = lcdc_decode(h_r.p2.dnc, h_r.p2.rnw, h_r.p2.data);

    // bus: selected read with strobe high; data reads wait for idle
    h_nxt.drive = sel && h_r.p2.strb && h_r.p2.rnw &&
                  (!h_r.p2.dnc || (!busy && !in_rst));
    // out_reg crosses clocks: take it only while no request is open,
    // since the phase side rewrites it before the ack comes back
    if (!h_r.p2.dnc) begin
      h_nxt.bus_out = status;
    end else if (!busy) begin
      h_nxt.bus_out = o_r.out_reg;
    end

    // strobe fall starts an operation; status read needs none
    if (fall && !busy && !in_rst && kind != OP_NONE) begin
      h_nxt.cmd.op   = kind;
      h_nxt.cmd.data = h_r.p2.data;
      h_nxt.req_tgl  = !h_r.req_tgl;
    end
  end

  // host-side register; reset takes constants only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      h_r         <= '0;
      h_r.rst_cnt <= 8'(RST_HOLD_CYC);
    end else begin
      h_r <= h_nxt;
    end
  end

  assign host_bus_o      = h_r.bus_out;
  assign host_bus_oe_n_o = !h_r.drive;

  // ---------------------------------------------------------------
  // phase-clock side: execute operations and scan the display
  // ---------------------------------------------------------------
  logic [PAGE_W+LINE_W-1:0] addr;   // current RAM byte address
  logic [PAGE_W+LINE_W-1:0] scan_a; // scan RAM byte address
  logic [LINE_W-1:0]        ci;     // RAM column for output i

  always_comb begin
    o_nxt = o_r;
    o_nxt.req1 = h_r.req_tgl;
    o_nxt.req2 = o_r.req1;
    o_nxt.fr1  = frame_sync_i;
    o_nxt.fr2  = o_r.fr1;
    o_nxt.fr_prev = o_r.fr2;
    o_nxt.ll1  = line_latch_i;
    o_nxt.ll2  = o_r.ll1;
    o_nxt.ll_prev = o_r.ll2;
    o_nxt.ac1  = ac_phase_i;
    o_nxt.ac2  = o_r.ac1;
    o_nxt.co1  = column_order_i;
    o_nxt.co2  = o_r.co1;
    addr   = ram_addr(o_r.page, o_r.col);
    scan_a = '0;
    ci     = '0;

    // a new request toggle: cmd has been stable since before it
    if (o_r.req2 != o_r.ack_tgl) begin
      o_nxt.ack_tgl = o_r.req2;
      case (h_r.cmd.op)
        OP_WRITE: begin
          o_nxt.ram[addr] = h_r.cmd.data;
          o_nxt.col = o_r.col + COL_STEP;
        end
        OP_READ: begin
          o_nxt.out_reg = o_r.ram[addr];
          o_nxt.col = o_r.col + COL_STEP;
        end
        OP_ONOFF: begin
          o_nxt.disp_on = h_r.cmd.data[0];
        end
        OP_START: begin
          o_nxt.start = h_r.cmd.data[LINE_W-1:0];
        end
        OP_PAGE: begin
          o_nxt.page = h_r.cmd.data[PAGE_W-1:0];
        end
        OP_COL: begin
          o_nxt.col = h_r.cmd.data[LINE_W-1:0];
        end
        default: begin
          o_nxt.ack_tgl = o_r.req2;
        end
      endcase
    end

    // rising line_latch: capture current line, then advance
    if (o_r.ll2 && !o_r.ll_prev) begin
      for (int c = 0; c < COLS; c++) begin
        scan_a = ram_addr(o_r.line[LINE_W-1:PAGE_W],
                          LINE_W'(c));
        o_nxt.latch[c] = o_r.ram[scan_a][o_r.line[PAGE_W-1:0]];
      end
      o_nxt.line = o_r.line + COL_STEP;
    end
    // rising frame_sync presets the counter; wins over the step
    if (o_r.fr2 && !o_r.fr_prev) begin
      o_nxt.line = o_r.start;
    end

    // segment drive, mirrored by column_order, blanked when off
    for (int i = 0; i < COLS; i++) begin
      ci = o_r.co2 ? LINE_W'(i) : LINE_W'(COLS - 1 - i);
      o_nxt.seg[i] = seg_level(o_r.ac2,
                               o_r.latch[ci] && o_r.disp_on);
    end
  end

  // phase-side register; reset clears every flop, the RAM included, except seg, which loads LVL_V4
  always_ff @(posedge phase_clk_i or posedge rst_i) begin
    if (rst_i) begin
      o_r         <= '0;
      o_r.disp_on <= DISP_RST;
      o_r.start   <= LINE_RST;
      for (int i = 0; i < COLS; i++) begin
        o_r.seg[i] <= LVL_V4;
      end
    end else begin
      o_r <= o_nxt;
    end
  end

  assign segment_outputs_o = o_r.seg;

endmodule : lcdc_core

// ### tb/lcdc_core_monitor.sv
`timescale 1ns/1ps
// bus drive and segment level checks, all in the clock_i domain
module lcdc_core_monitor (
  input wire logic                        clock_i,
  input wire logic                        rst_i,
  input wire logic                        host_strb_i,
  input wire logic                        chip_sel_n_a_i,
  input wire logic                        chip_sel_n_b_i,
  input wire logic                        chip_sel_c_i,
  input wire logic                        read_not_write_i,
  input wire logic                        data_or_cmd_i,
  input wire logic                        ac_phase_i,
  input wire logic [lcdc_pkg::BUS_W-1:0]  host_bus_o,
  input wire logic                        host_bus_oe_n_o,
  input wire lcdc_pkg::lcdc_lvl_t [lcdc_pkg::COLS-1:0] segment_outputs_o
);
  import lcdc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic sel;  // all three selects active
  logic rd;   // selected read with strobe high
  logic st;   // selected status read with strobe high
  assign sel = !chip_sel_n_a_i && !chip_sel_n_b_i && chip_sel_c_i;
  assign rd  = sel && read_not_write_i && host_strb_i;
  assign st  = rd && !data_or_cmd_i;
  // the sync chain and drive flop lag the pins by three edges; checked at two to four
  property p_drive_cause;
    !host_bus_oe_n_o |-> $past(rd, 2) || $past(rd, 3) || $past(rd, 4);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("bus driven without a selected read");
  property p_status_drive;
    st [*4] |=> !host_bus_oe_n_o;
  endproperty
  a_status_drive: assert property (p_status_drive)
    else $error("status read not answered");
  property p_release;
    (!host_strb_i) [*5] |-> host_bus_oe_n_o;
  endproperty
  a_release: assert property (p_release)
    else $error("bus still driven after strobe fall");
  property p_deselect;
    (!sel) [*5] |-> host_bus_oe_n_o;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("bus driven while deselected");
  property p_write_quiet;
    (!read_not_write_i) [*5] |-> host_bus_oe_n_o;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("bus driven during a write");
  property p_status_fmt;
    !host_bus_oe_n_o && !data_or_cmd_i && $past(data_or_cmd_i, 5) == 1'b0
      |-> host_bus_o[6] == 1'b0 && host_bus_o[3:0] == 4'h0;
  endproperty
  a_status_fmt: assert property (p_status_fmt)
    else $error("status byte has stray bits");
  property p_reset_state;
    $fell(rst_i) |-> host_bus_oe_n_o && segment_outputs_o[0] == LVL_V4
      && segment_outputs_o[COLS-1] == LVL_V4;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset not blank");
  property p_ac_high;
    ac_phase_i [*8] |-> segment_outputs_o[0] inside {LVL_V1, LVL_V3};
  endproperty
  a_ac_high: assert property (p_ac_high)
    else $error("segment level off phase high");
  property p_ac_low;
    (!ac_phase_i) [*8] |-> segment_outputs_o[COLS-1] inside {LVL_V2, LVL_V4};
  endproperty
  a_ac_low: assert property (p_ac_low)
    else $error("segment level off phase low");
endmodule : lcdc_core_monitor

bind lcdc_core lcdc_core_monitor u_mon (
  .clock_i(clock_i), .rst_i(rst_i), .host_strb_i(host_strb_i),
  .chip_sel_n_a_i(chip_sel_n_a_i), .chip_sel_n_b_i(chip_sel_n_b_i),
  .chip_sel_c_i(chip_sel_c_i), .read_not_write_i(read_not_write_i),
  .data_or_cmd_i(data_or_cmd_i), .ac_phase_i(ac_phase_i),
  .host_bus_o(host_bus_o), .host_bus_oe_n_o(host_bus_oe_n_o),
  .segment_outputs_o(segment_outputs_o)
);

// ### tb/lcdc_row_drv.sv
`timescale 1ns/1ps
// stand-in for the row driver: phase clock plus frame and line timing
module lcdc_row_drv (
  output logic phase_clk_o,
  output logic frame_sync_o,
  output logic line_latch_o,
  output logic ac_phase_o
);
  // free-running phase clock, offset so it never lines up with clock_i
  initial begin
    {phase_clk_o, frame_sync_o, line_latch_o, ac_phase_o} = 4'h0;
    #3.7;
    forever #7.5 phase_clk_o = ~phase_clk_o;
  end
  // pulses last four phase clocks, wide enough for the two-stage sync
  task automatic pulse(input logic frame);
    @(posedge phase_clk_o);
    if (frame) frame_sync_o <= 1'b1;
    else line_latch_o <= 1'b1;
    repeat (4) @(posedge phase_clk_o);
    {frame_sync_o, line_latch_o} <= 2'h0;
    repeat (4) @(posedge phase_clk_o);
  endtask : pulse
  task automatic set_ac(input logic v);
    @(posedge phase_clk_o);
    ac_phase_o <= v;
  endtask : set_ac
endmodule : lcdc_row_drv

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lcdc_pkg::*;
  logic                 clock_i, rst_i, strb, csa, csb, csc, rnw, dnc;
  logic                 col_ord, oe_n, oe_seen, phase_clk, frame_sync, cl, ac;
  logic [BUS_W-1:0]     host_d, bus_o, bus_w, q;
  lcdc_lvl_t [COLS-1:0] seg;
  int                   n_fail, n_tests;
  // wire level: the device value while it drives, else the host value
  assign bus_w = oe_n ? host_d : bus_o;
  lcdc_core u_dut (
    .clock_i(clock_i), .phase_clk_i(phase_clk), .rst_i(rst_i),
    .host_strb_i(strb), .chip_sel_n_a_i(csa), .chip_sel_n_b_i(csb),
    .chip_sel_c_i(csc), .read_not_write_i(rnw), .data_or_cmd_i(dnc),
    .host_bus_i(bus_w), .host_bus_o(bus_o), .host_bus_oe_n_o(oe_n),
    .column_order_i(col_ord), .ac_phase_i(ac), .frame_sync_i(frame_sync),
    .line_latch_i(cl), .segment_outputs_o(seg));
  lcdc_row_drv u_row (.phase_clk_o(phase_clk), .frame_sync_o(frame_sync),
    .line_latch_o(cl), .ac_phase_o(ac));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic chk(input string what, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one strobe cycle; pins lead the strobe by a cycle and hold past fall
  task automatic xfer(input logic [2:0] cs, input logic d, r,
                      input logic [7:0] v);
    @(posedge clock_i);
    {csa, csb, csc, dnc, rnw} <= {cs, d, r};
    host_d <= r ? ~host_d : v;  // a released bus never repeats a value
    @(posedge clock_i);
    strb <= 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    q = bus_w;
    oe_seen = oe_n;
    @(posedge clock_i);
    strb <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : xfer
  // selected access, then status polls until the busy flag drops
  task automatic op(input logic d, r, input logic [7:0] v);
    logic [7:0] keep;
    xfer(3'b001, d, r, v);
    keep = q;
    q = 8'h80;
    for (int i = 0; i < 40 && q[7] !== 1'b0; i++)
      xfer(3'b001, 1'b0, 1'b1, 8'h00);
    chk("busy", q & 8'h80, 8'h00);
    q = keep;
  endtask : op
  task automatic sg(input int i, input lcdc_lvl_t e);
    chk("segment", {6'h00, seg[i]}, {6'h00, e});
  endtask : sg
  // optional frame preset, one line latch, then let segments settle
  task automatic scan(input logic f);
    if (f) u_row.pulse(1'b1);
    u_row.pulse(1'b0);
    repeat (6) @(posedge clock_i);
  endtask : scan
  task automatic t_reset();
    xfer(3'b001, 1'b0, 1'b1, 8'h00);
    chk("status in reset window", q & 8'h30, 8'h30);
    op(1'b0, 1'b1, 8'h00);
    chk("status after reset", q, 8'h20);
  endtask : t_reset
  task automatic t_ram();
    op(1'b0, 1'b0, 8'hB8);
    op(1'b0, 1'b0, 8'h7F);
    op(1'b1, 1'b0, 8'hA4);
    op(1'b1, 1'b0, 8'h01);
    op(1'b1, 1'b0, 8'h5A);
    op(1'b0, 1'b0, 8'h7F);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk("read column 63", q, 8'hA4);
    op(1'b0, 1'b0, 8'h41);
    op(1'b1, 1'b1, 8'h00);
    chk("staged byte kept", q, 8'h01);
    op(1'b1, 1'b1, 8'h00);
    chk("read column 1", q, 8'h5A);
  endtask : t_ram
  task automatic t_disp();
    u_row.set_ac(1'b1);
    op(1'b0, 1'b0, 8'h3F);
    op(1'b0, 1'b1, 8'h00);
    chk("status on", q, 8'h00);
    scan(1'b1);
    sg(0, LVL_V1);
    sg(63, LVL_V3);
    col_ord <= 1'b0;
    u_row.set_ac(1'b0);
    scan(1'b1);
    sg(0, LVL_V4);
    sg(63, LVL_V2);
    op(1'b0, 1'b0, 8'hC1);
    scan(1'b1);
    sg(62, LVL_V2);
    scan(1'b0);
    sg(0, LVL_V2);
    sg(62, LVL_V4);
  endtask : t_disp
  task automatic t_desel();
    logic [2:0] bad [3] = '{3'b101, 3'b011, 3'b000};
    foreach (bad[i]) begin
      xfer(bad[i], 1'b0, 1'b0, 8'h3E);
      xfer(bad[i], 1'b0, 1'b1, 8'h00);
      chk("drive when deselected", {7'h00, oe_seen}, 8'h01);
    end
    col_ord <= 1'b1;
    scan(1'b1);
    sg(1, LVL_V2);
    op(1'b0, 1'b1, 8'h00);
    chk("display still on", q, 8'h00);
  endtask : t_desel
  task automatic t_off();
    op(1'b0, 1'b0, 8'h3E);
    op(1'b0, 1'b1, 8'h00);
    chk("status off", q, 8'h20);
    scan(1'b1);
    sg(1, LVL_V4);
    op(1'b0, 1'b0, 8'h3F);
    scan(1'b1);
    sg(1, LVL_V2);
  endtask : t_off
  // mid-run reset: display off and start line back to 0
  task automatic t_rerst();
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    op(1'b1, 1'b0, 8'h01);
    op(1'b0, 1'b0, 8'h3F);
    scan(1'b1);
    sg(0, LVL_V2);
  endtask : t_rerst
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // whole run is under a thousand cycles; twenty times that is a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {strb, csa, csb, csc, rnw, dnc, col_ord, oe_seen} = 8'h1B;
    {rst_i, host_d, q, n_fail, n_tests} = {1'b1, 16'h0000, 64'h0};
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_ram();
    t_disp();
    t_desel();
    t_off();
    t_rerst();
    tally_and_finish();
  end
endmodule : testbench
